// ### bench/channel_register_set_select_tb_top.sv
// testbench for the register-set selection block.
// assumes the smbus host model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module channel_register_set_select_tb_top;
  import regsel_pkg::*;
  localparam logic [3:0] STRAP = 4'h5;
  localparam logic [6:0] DEV   = SMB_BASE_ADDR + 7'(STRAP);
  localparam logic [3:0] ALT_STRAP = 4'ha;
  localparam logic [6:0] ALT_DEV   = SMB_BASE_ADDR + 7'(ALT_STRAP);
  logic [3:0] strap_pin = STRAP;
  logic       clk     = 1'b0;
  logic       reset_n = 1'b0;
  logic       scl, sda_drv, sda_out, sda_oe, bc, en;
  logic [1:0] ch;
  int         fails, tests_run, cycles;
  wire        sda_w = sda_drv & ~(sda_oe & ~sda_out);

  always #2.5 clk = ~clk;

  channel_register_set_select DUT (.clk(clk), .reset_n(reset_n), .scl(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap_pin),
    .broadcast_write_enable(bc), .channel_space_enable(en), .target_channel_index(ch));
  smbus_host_model host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_w));

  // ****
  // checks and bus helpers
  // ****
  task automatic check8(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic check_sel(input logic [3:0] e);
    check8("selection", {4'h0, e}, {4'h0, bc, en, ch});
  endtask

  task automatic wr(input logic [7:0] r, d);
    logic ok;
    host.write_reg(DEV, r, d, ok);
    check8("write ack", 8'h01, {7'h00, ok});
  endtask

  task automatic rd(input logic [7:0] r, e);
    logic [7:0] d;
    logic       ok;
    host.read_reg(DEV, r, d, ok);
    check8("read ack", 8'h01, {7'h00, ok});
    check8("read data", e, d);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****
  // scenarios
  // ****
  task automatic sc_defaults();
    logic ok;
    check_sel(4'h0);
    rd(8'h00, {STRAP, 4'h0});
    rd(8'h04, 8'h01);
    rd(8'h07, 8'h05);
    wr(8'h00, 8'hff);
    rd(8'h00, {STRAP, 4'h0});
    wr(8'h05, 8'hff);
    rd(8'h05, 8'hf0);
    wr(8'h02, 8'ha5);
    host.write_reg(DEV + 7'h01, 8'hff, 8'h04, ok);
    check8("foreign ack", 8'h00, {7'h00, ok});
    check_sel(4'h0);
  endtask

  task automatic sc_single();
    for (int c = 0; c < 4; c++) begin
      wr(8'hff, 8'h04 | 8'(c));
      check_sel(4'h4 | 4'(c));
      wr(8'h00, 8'h10 + 8'(c));
      wr(8'h02, 8'h20 + 8'(c));
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'hff, 8'h04 | 8'(c));
      rd(8'h00, 8'h10 + 8'(c));
      rd(8'h02, 8'h20 + 8'(c));
    end
    wr(8'hff, 8'h00);
    rd(8'h02, 8'ha5);
    rd(8'h00, {STRAP, 4'h0});
  endtask

  task automatic sc_broadcast();
    wr(8'hff, 8'h0c);
    check_sel(4'hc);
    wr(8'h30, 8'h3c);
    for (int c = 0; c < 4; c++) begin
      wr(8'hff, 8'h0c | 8'(c));
      rd(8'h30, 8'h3c);
      rd(8'h00, 8'h10 + 8'(c));
    end
  endtask

  task automatic sc_select_reg();
    wr(8'hff, 8'h05);
    wr(8'hff, 8'h06);
    check_sel(4'h6);
    rd(8'hff, SEL_READ_VALUE);
    check_sel(4'h6);
    wr(8'hff, 8'h08);
    check_sel(4'h8);
    wr(8'h02, 8'h77);
    wr(8'hff, 8'h00);
    rd(8'h02, 8'h77);
    wr(8'hff, 8'h06);
    rd(8'h02, 8'h22);
  endtask

  // reset in mid-run with a new strap: selection clears, address follows the strap
  task automatic sc_reset();
    logic [7:0] d;
    logic       ok;
    wr(8'hff, 8'h0e);
    check_sel(4'he);
    @(negedge clk);
    reset_n   = 1'b0;
    strap_pin = ALT_STRAP;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    check_sel(4'h0);
    host.read_reg(ALT_DEV, 8'h00, d, ok);
    check8("strap ack", 8'h01, {7'h00, ok});
    check8("strap read", {ALT_STRAP, 4'h0}, d);
    host.write_reg(DEV, 8'hff, 8'h04, ok);
    check8("old address ack", 8'h00, {7'h00, ok});
    check_sel(4'h0);
  endtask

  // ****
  // run control
  // ****
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      $display("FAIL timeout exp done got hang");
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    sc_defaults();
    sc_single();
    sc_broadcast();
    sc_select_reg();
    sc_reset();
    print_verdict();
  end
endmodule // channel_register_set_select_tb_top
`default_nettype wire

// ### bench/smbus_host_model.sv
// smbus host model: byte-write and byte-read transactions, msb first.
// assumes the bench resolves sda with a pull-up from all enables.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  // clock
  input  wire logic clk,
  // bus
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // ****
  // bus phases
  // ****
  task automatic ph();
    repeat (4) @(negedge clk);
  endtask

  // also serves as repeated start after an ack slot
  task automatic start();
    sda_drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b0;
    ph();
    scl = 1'b0;
    ph();
  endtask

  task automatic stop();
    sda_drv = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_drv = 1'b1;
    ph();
  endtask

  task automatic tx(input logic [7:0] b, inout logic ok);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      ph();
      scl = 1'b1;
      ph();
      scl = 1'b0;
    end
    sda_drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    ok &= ~sda_wire;
    scl = 1'b0;
    ph();
  endtask

  // single byte then nack
  task automatic rx(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      ph();
      scl = 1'b1;
      ph();
      d[i] = sda_wire;
      scl = 1'b0;
    end
    sda_drv = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    scl = 1'b0;
    ph();
  endtask

  // ****
  // transactions
  // ****
  task automatic write_reg(input logic [6:0] a, input logic [7:0] r, d,
                           output logic ok);
    ok = 1'b1;
    start();
    tx({a, 1'b0}, ok);
    tx(r, ok);
    tx(d, ok);
    stop();
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [7:0] r,
                          output logic [7:0] d, output logic ok);
    ok = 1'b1;
    start();
    tx({a, 1'b0}, ok);
    tx(r, ok);
    start();
    tx({a, 1'b1}, ok);
    rx(d);
    stop();
  endtask
endmodule // smbus_host_model
`default_nettype wire

// ### pkg/regsel_pkg.sv
// constants, shared-register layout, state codes and decode helpers for the
// register-set selection block.
// assumes nothing beyond a SystemVerilog compiler.
package regsel_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH  = 4;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int STRAP_W = 4;
  localparam int CH_W    = 2;

  // ****************************************
  // select register
  // ****************************************
  localparam logic [7:0] SEL_ADDR       = 8'hff;
  localparam logic [7:0] SEL_RESET      = 8'h00;
  localparam logic [7:0] SEL_READ_VALUE = 8'h00;
  localparam int         SEL_BCAST_BIT  = 3;
  localparam int         SEL_EN_BIT     = 2;
  localparam int         SEL_CH_LSB     = 0;

  // ****************************************
  // smbus framing
  // ****************************************
  localparam logic [6:0] SMB_BASE_ADDR = 7'h18;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;

  // ****************************************
  // shared registers
  // ****************************************
  localparam int         SH_NUM        = 8;
  localparam logic [7:0] SH_STRAP_ADDR = 8'h00;
  localparam logic [7:0] SH_ID_ADDR    = 8'h01;
  localparam logic [7:0] SH_SC_ADDR    = 8'h04;
  localparam logic [7:0] SH_STAT_ADDR  = 8'h05;
  localparam logic [7:0] SH_SC_MASK    = 8'h60;
  localparam logic [7:0] SH_STAT_RO    = 8'h10;
  localparam logic [7:0] SH_RESET   [SH_NUM] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                                 8'h01, 8'h00, 8'h00, 8'h05};
  localparam logic [7:0] SH_RW_MASK [SH_NUM] = '{8'h00, 8'h00, 8'hff, 8'h00,
                                                 8'hff, 8'he0, 8'hff, 8'hff};

  // ****************************************
  // smbus slave states
  // ****************************************
  typedef enum logic [9:0] {
    st_idle      = 10'h001,
    st_addr      = 10'h002,
    st_ack_addr  = 10'h004,
    st_reg       = 10'h008,
    st_ack_reg   = 10'h010,
    st_wdata     = 10'h020,
    st_ack_wdata = 10'h040,
    st_rdata     = 10'h080,
    st_rack      = 10'h100,
    st_wait      = 10'h200
  } smb_state_e;

  // ****************************************
  // decode helpers
  // ****************************************
  // channel sets a write reaches; the broadcast bit counts only while the enable bit is set
  function automatic logic [NUM_CH-1:0] chan_wr_mask(input logic [7:0] sel);
    logic [NUM_CH-1:0] m;
    m = '0;
    if (sel[SEL_EN_BIT]) begin
      if (sel[SEL_BCAST_BIT]) begin
        m = '1;
      end else begin
        m[sel[SEL_CH_LSB +: CH_W]] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [CH_W-1:0] chan_rd_index(input logic [7:0] sel);
    return sel[SEL_CH_LSB +: CH_W];
  endfunction

endpackage

// ### verilog/chan_reg_mem.sv
// four channel register sets, each a full address space of bytes.
// assumes write mask and read request come from the smbus slave, one cycle each.
`timescale 1ns/1ps
`default_nettype none
module chan_reg_mem #(
  parameter int NUM_CH = regsel_pkg::NUM_CH,
  parameter int ADDR_W = regsel_pkg::ADDR_W,
  parameter int DATA_W = regsel_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  // access
  input  wire logic [NUM_CH-1:0]               we_mask,
  input  wire logic [ADDR_W-1:0]               addr,
  input  wire logic [DATA_W-1:0]               wdata,
  input  wire logic                            re,
  input  wire logic [$clog2(NUM_CH)-1:0]       rd_ch,
  // read data
  output logic      [DATA_W-1:0]               rd_data_r
);
  import regsel_pkg::*;

  logic [DATA_W-1:0] rd_word [NUM_CH];
  logic [DATA_W-1:0] rd_data_nxt;

  // ****************************************
  // one register set per channel
  // ****************************************
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_set
    logic [DATA_W-1:0] mem [2**ADDR_W];
    always_ff @(posedge clk) begin
      if (we_mask[ch]) begin
        mem[addr] <= wdata;
      end
    end
    assign rd_word[ch] = mem[addr];
  end

  // ****************************************
  // registered read port
  // ****************************************
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (re) begin
      rd_data_nxt = rd_word[rd_ch];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

endmodule // chan_reg_mem
`default_nettype wire

// ### verilog/channel_register_set_select.sv
// smbus slave with the register-set select register and its routing.
// assumes scl and sda are already synchronous to clk and sda is open-drain.
`timescale 1ns/1ps
`default_nettype none
module channel_register_set_select (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  // smbus pins
  input  wire logic                           scl,
  input  wire logic                           sda_in,
  output logic                                sda_out,
  output logic                                sda_oe,
  // address strap
  input  wire logic [regsel_pkg::STRAP_W-1:0] addr_strap,
  // current selection
  output logic                                broadcast_write_enable,
  output logic                                channel_space_enable,
  output logic [regsel_pkg::CH_W-1:0]         target_channel_index
);
  import regsel_pkg::*;

  // ****************************************
  // state
  // ****************************************
  smb_state_e          state_r,      state_nxt;
  logic [3:0]          bits_r,       bits_nxt;
  logic [7:0]          shift_r,      shift_nxt;
  logic [7:0]          tx_r,         tx_nxt;
  logic [ADDR_W-1:0]   ptr_r,        ptr_nxt;
  logic [7:0]          select_r,     select_nxt;
  logic                sda_oe_r,     sda_oe_nxt;
  logic                src_sel_r,    src_sel_nxt;
  logic                src_chan_r,   src_chan_nxt;
  logic                scl_q_r;
  logic                sda_q_r;
  logic                sda_out_r;
  logic [STRAP_W-1:0]  strap_r;
  logic                strap_taken_r;

  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic                wr_fire;
  logic                rd_fire;
  logic                ptr_is_sel;
  logic [6:0]          dev_addr;
  logic [DATA_W-1:0]   read_mux;
  logic [NUM_CH-1:0]   mem_we_mask;
  logic                mem_re;
  logic                sh_we;
  logic                sh_re;
  logic [DATA_W-1:0]   mem_rd;
  logic [DATA_W-1:0]   sh_rd;

  // ****************************************
  // pin sampling and bus conditions
  // ****************************************
  assign scl_rise  = scl & ~scl_q_r;
  assign scl_fall  = ~scl & scl_q_r;
  assign start_det = scl & scl_q_r & sda_q_r & ~sda_in;
  assign stop_det  = scl & scl_q_r & ~sda_q_r & sda_in;

  assign dev_addr   = 7'(SMB_BASE_ADDR + {3'h0, strap_r});
  assign ptr_is_sel = (ptr_r == SEL_ADDR);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_q_r       <= 1'b1;
      sda_q_r       <= 1'b1;
      sda_out_r     <= 1'b0;
      strap_r       <= '0;
      strap_taken_r <= 1'b0;
    end else begin
      scl_q_r       <= scl;
      sda_q_r       <= sda_in;
      sda_out_r     <= 1'b0;
      if (!strap_taken_r) begin
        strap_r       <= addr_strap;
        strap_taken_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // read source mux
  // ****************************************
  always_comb begin
    if (src_sel_r) begin
      read_mux = SEL_READ_VALUE;
    end else if (src_chan_r) begin
      read_mux = mem_rd;
    end else begin
      read_mux = sh_rd;
    end
  end

  // ****************************************
  // smbus slave sequencing
  // ****************************************
  always_comb begin
    state_nxt    = state_r;
    bits_nxt     = bits_r;
    shift_nxt    = shift_r;
    tx_nxt       = tx_r;
    ptr_nxt      = ptr_r;
    sda_oe_nxt   = sda_oe_r;
    wr_fire      = 1'b0;
    rd_fire      = 1'b0;
    if (start_det) begin
      state_nxt  = st_addr;
      bits_nxt   = '0;
      sda_oe_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt  = st_idle;
      sda_oe_nxt = 1'b0;
    end else begin
      case (state_r)
        st_idle: begin
          state_nxt = st_idle;
        end
        st_addr, st_reg, st_wdata: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_in};
            bits_nxt  = 4'(bits_r + 4'h1);
          end else if (scl_fall && bits_r == BYTE_BITS) begin
            bits_nxt   = '0;
            sda_oe_nxt = 1'b1;
            if (state_r == st_addr) begin
              if (shift_r[7:1] == dev_addr) begin
                state_nxt = st_ack_addr;
                rd_fire   = shift_r[0];
              end else begin
                state_nxt  = st_wait;
                sda_oe_nxt = 1'b0;
              end
            end else if (state_r == st_reg) begin
              ptr_nxt   = shift_r;
              state_nxt = st_ack_reg;
            end else begin
              wr_fire   = 1'b1;
              state_nxt = st_ack_wdata;
            end
          end
        end
        st_ack_addr: begin
          if (scl_fall) begin
            if (shift_r[0]) begin
              state_nxt  = st_rdata;
              tx_nxt     = read_mux;
              sda_oe_nxt = ~read_mux[7];
            end else begin
              state_nxt  = st_reg;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        st_ack_reg: begin
          if (scl_fall) begin
            state_nxt  = st_wdata;
            sda_oe_nxt = 1'b0;
          end
        end
        st_ack_wdata: begin
          if (scl_fall) begin
            state_nxt  = st_wait;
            sda_oe_nxt = 1'b0;
          end
        end
        st_rdata: begin
          if (scl_fall) begin
            bits_nxt = 4'(bits_r + 4'h1);
            if (bits_r == LAST_TX_BIT) begin
              state_nxt  = st_rack;
              sda_oe_nxt = 1'b0;
            end else begin
              tx_nxt     = {tx_r[6:0], 1'b0};
              sda_oe_nxt = ~tx_r[6];
            end
          end
        end
        st_rack: begin
          if (scl_rise) begin
            state_nxt = st_wait;
          end
        end
        st_wait: begin
          state_nxt = st_wait;
        end
        default: begin
          state_nxt  = st_idle;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // routing of accesses
  // ****************************************
  always_comb begin
    select_nxt   = select_r;
    src_sel_nxt  = src_sel_r;
    src_chan_nxt = src_chan_r;
    mem_we_mask  = '0;
    sh_we        = 1'b0;
    mem_re       = 1'b0;
    sh_re        = 1'b0;
    if (wr_fire) begin
      if (ptr_is_sel) begin
        select_nxt = shift_r;
      end else if (select_r[SEL_EN_BIT]) begin
        mem_we_mask = chan_wr_mask(select_r);
      end else begin
        sh_we = 1'b1;
      end
    end
    if (rd_fire) begin
      src_sel_nxt  = ptr_is_sel;
      src_chan_nxt = ~ptr_is_sel & select_r[SEL_EN_BIT];
      mem_re       = ~ptr_is_sel & select_r[SEL_EN_BIT];
      sh_re        = ~ptr_is_sel & ~select_r[SEL_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r    <= st_idle;
      bits_r     <= '0;
      shift_r    <= '0;
      tx_r       <= '0;
      ptr_r      <= '0;
      select_r   <= SEL_RESET;
      sda_oe_r   <= 1'b0;
      src_sel_r  <= 1'b0;
      src_chan_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bits_r     <= bits_nxt;
      shift_r    <= shift_nxt;
      tx_r       <= tx_nxt;
      ptr_r      <= ptr_nxt;
      select_r   <= select_nxt;
      sda_oe_r   <= sda_oe_nxt;
      src_sel_r  <= src_sel_nxt;
      src_chan_r <= src_chan_nxt;
    end
  end

  assign sda_out                = sda_out_r;
  assign sda_oe                 = sda_oe_r;
  assign broadcast_write_enable = select_r[SEL_BCAST_BIT];
  assign channel_space_enable   = select_r[SEL_EN_BIT];
  assign target_channel_index   = select_r[SEL_CH_LSB +: CH_W];

  // ****************************************
  // register sets
  // ****************************************
  chan_reg_mem u_chan (
    .clk       (clk),
    .reset_n   (reset_n),
    .we_mask   (mem_we_mask),
    .addr      (ptr_r),
    .wdata     (shift_r),
    .re        (mem_re),
    .rd_ch     (chan_rd_index(select_r)),
    .rd_data_r (mem_rd)
  );

  shared_regs u_shared (
    .clk       (clk),
    .reset_n   (reset_n),
    .we        (sh_we),
    .re        (sh_re),
    .addr      (ptr_r),
    .wdata     (shift_r),
    .strap     (strap_r),
    .rd_data_r (sh_rd)
  );

  // ****************************************
  // checks
  // ****************************************
  a_sel_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !(wr_fire && ptr_is_sel) |=> $stable(select_r))
    else $error("select changed without a write to its address");

  a_sel_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_fire && ptr_is_sel) |=> (select_r == $past(shift_r)) && !$past(sh_we))
    else $error("select write did not land in select register");

  a_no_chan_ff: assert property (@(posedge clk) disable iff (!reset_n)
    (mem_we_mask != '0) |-> !ptr_is_sel)
    else $error("channel write at select address");

  a_bcast_all: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_fire && !ptr_is_sel && select_r[SEL_EN_BIT] && select_r[SEL_BCAST_BIT])
      |-> mem_we_mask == 4'hf)
    else $error("broadcast write missed a channel");

  a_single_chan: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_fire && !ptr_is_sel && select_r[SEL_EN_BIT] && !select_r[SEL_BCAST_BIT])
      |-> mem_we_mask == 4'(4'h1 << select_r[SEL_CH_LSB +: CH_W]))
    else $error("single channel write went to wrong set");

  a_shared_off: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_fire && !ptr_is_sel && !select_r[SEL_EN_BIT]) |-> sh_we && mem_we_mask == '0)
    else $error("write with channels disabled missed shared set");

  a_read_chan: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_fire && !ptr_is_sel && select_r[SEL_EN_BIT]) |-> mem_re && !sh_re ##1 src_chan_r)
    else $error("channel read not routed to channel set");

  a_addr_ack: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == st_addr && state_nxt == st_ack_addr && !start_det)
      |-> shift_r[7:1] == dev_addr ##1 sda_oe_r)
    else $error("acknowledged a foreign address");

endmodule // channel_register_set_select
`default_nettype wire

// ### verilog/shared_regs.sv
// shared control registers below the select register address.
// assumes one-cycle write and read requests and a strap captured after reset.
`timescale 1ns/1ps
`default_nettype none
module shared_regs #(
  // arbitrary identity value
  parameter logic [7:0] DEVICE_ID = 8'h5a
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  // access
  input  wire logic                           we,
  input  wire logic                           re,
  input  wire logic [regsel_pkg::ADDR_W-1:0]  addr,
  input  wire logic [regsel_pkg::DATA_W-1:0]  wdata,
  input  wire logic [regsel_pkg::STRAP_W-1:0] strap,
  // read data
  output logic      [regsel_pkg::DATA_W-1:0]  rd_data_r
);
  import regsel_pkg::*;

  logic [DATA_W-1:0] regs_r   [SH_NUM];
  logic [DATA_W-1:0] regs_nxt [SH_NUM];
  logic [DATA_W-1:0] rd_data_nxt;
  logic [DATA_W-1:0] rd_value;

  // ****************************************
  // storage, read-only bits never written
  // ****************************************
  always_comb begin
    for (int i = 0; i < SH_NUM; i++) begin
      regs_nxt[i] = regs_r[i];
      if (8'(i) == SH_SC_ADDR) begin
        regs_nxt[i] = regs_r[i] & ~SH_SC_MASK;
      end
      if (we && addr == 8'(i)) begin
        regs_nxt[i] = (regs_r[i] & ~SH_RW_MASK[i]) | (wdata & SH_RW_MASK[i]);
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_value = '0;
    if (addr == SH_STRAP_ADDR) begin
      rd_value = {strap, 4'h0};
    end else if (addr == SH_ID_ADDR) begin
      rd_value = DEVICE_ID;
    end else if (addr == SH_STAT_ADDR) begin
      rd_value = (regs_r[SH_STAT_ADDR[2:0]] & SH_RW_MASK[SH_STAT_ADDR[2:0]]) | SH_STAT_RO;
    end else if (addr < 8'(SH_NUM)) begin
      rd_value = regs_r[addr[2:0]] & SH_RW_MASK[addr[2:0]];
    end
    rd_data_nxt = re ? rd_value : rd_data_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regs_r    <= SH_RESET;
      rd_data_r <= '0;
    end else begin
      regs_r    <= regs_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

endmodule // shared_regs
`default_nettype wire
